// ==== pin_sync.sv ====
/*
 * Two-flip-flop synchroniser for a bus of pin levels.
 * Assumes the pins change without regard to clk.
 */
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] sync_r;
    logic [WIDTH-1:0] sync_nxt;

    always_comb begin
        meta_nxt = async_in;
        sync_nxt = meta_r;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign sync_out = sync_r;
endmodule // pin_sync
`default_nettype wire

// ==== port_c_gpio.sv ====
/*
 * Third general-purpose port: direction, latch and pin-read registers
 * behind an AXI4-Lite slave, with peripheral overrides on pins 0 to 3.
 * Assumes peripheral enables and outputs arrive synchronous to clk and
 * that pads resolve pin_o/pin_oe externally.
 */
`timescale 1ns/1ns
`default_nettype none
module port_c_gpio
    import port_c_pkg::*;
#(
    parameter int WIDTH = port_c_pkg::PORT_WIDTH
) (
    input wire logic clk,
    input wire logic rstn,
    // AXI4-Lite slave.
    input wire logic [port_c_pkg::ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [port_c_pkg::ADDR_WIDTH-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pads.
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] pin_o,
    output logic [WIDTH-1:0] pin_oe,
    output logic [1:0] osc_analog_en,
    // Peripheral side.
    input wire logic low_freq_osc_en,
    input wire logic capture2_en,
    input wire logic capture2_out,
    output logic capture2_in,
    output logic capture2_alt_sel,
    input wire logic capture1_en,
    input wire logic capture1_out,
    output logic capture1_in,
    input wire logic pwm_a_en,
    input wire logic pwm_a_out,
    input wire logic pwm_shutdown,
    input wire logic spi_en,
    input wire logic spi_clock_out,
    output logic spi_clock_in,
    input wire logic two_wire_en,
    input wire logic two_wire_clock_out,
    input wire logic two_wire_clock_drive,
    output logic two_wire_clock_in,
    output logic two_wire_smbus_levels,
    output logic secondary_timer_count_in
);
    import port_c_pkg::*;

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [WIDTH-1:0] latch_r;
    logic [WIDTH-1:0] latch_nxt;
    logic [WIDTH-1:0] dir_r;
    logic [WIDTH-1:0] dir_nxt;
    logic [CTL_WIDTH-1:0] ctl_r;
    logic [CTL_WIDTH-1:0] ctl_nxt;
    logic [WIDTH-1:0] pins_sync;
    logic [WIDTH-1:0] eff_dir;
    logic [WIDTH-1:0] eff_out;
    logic [WIDTH-1:0] digital_off;

    // Pin levels are read only after the two synchroniser flops.
    pin_sync #(.WIDTH(WIDTH)) u_sync (
        .clk(clk),
        .rstn(rstn),
        .async_in(pin_i),
        .sync_out(pins_sync)
    );

    // ****************************************************************
    // AXI4-Lite channels
    // ****************************************************************
    logic aw_held_r;
    logic aw_held_nxt;
    logic w_held_r;
    logic w_held_nxt;
    logic [ADDR_WIDTH-1:0] awaddr_r;
    logic [ADDR_WIDTH-1:0] awaddr_nxt;
    logic [31:0] wdata_r;
    logic [31:0] wdata_nxt;
    logic [3:0] wstrb_r;
    logic [3:0] wstrb_nxt;
    logic bvalid_r;
    logic bvalid_nxt;
    logic [1:0] bresp_r;
    logic [1:0] bresp_nxt;
    logic rvalid_r;
    logic rvalid_nxt;
    logic [1:0] rresp_r;
    logic [1:0] rresp_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic do_write;
    logic [31:0] rd_word;
    logic rd_hit;

    // An item is refused while it is already held or a response waits,
    // so that one write at most is in flight.
    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready = !w_held_r && !bvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign do_write = aw_held_r && w_held_r && !bvalid_r;

    always_comb begin
        aw_held_nxt = aw_held_r;
        w_held_nxt = w_held_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        latch_nxt = latch_r;
        dir_nxt = dir_r;
        ctl_nxt = ctl_r;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_nxt = 1'b1;
            awaddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_nxt = 1'b1;
            wdata_nxt = s_axi_wdata;
            wstrb_nxt = s_axi_wstrb;
        end
        if (do_write) begin
            aw_held_nxt = 1'b0;
            w_held_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = RESP_OKAY;
            // Byte lane zero carries every field; other lanes are ignored.
            if (wstrb_r[0]) begin
                unique case (awaddr_r)
                    PIN_DATA_ADDR, LATCH_ADDR: begin
                        latch_nxt = wdata_r[WIDTH-1:0]; // R04 R17
                    end
                    DIRECTION_ADDR: begin
                        dir_nxt = wdata_r[WIDTH-1:0];
                    end
                    CONTROL_ADDR: begin
                        ctl_nxt = wdata_r[CTL_WIDTH-1:0];
                    end
                    default: begin
                        bresp_nxt = RESP_SLVERR;
                    end
                endcase
            end else if (awaddr_r != PIN_DATA_ADDR && awaddr_r != LATCH_ADDR
                    && awaddr_r != DIRECTION_ADDR
                    && awaddr_r != CONTROL_ADDR) begin
                bresp_nxt = RESP_SLVERR;
            end
        end
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
    end

    // ****************************************************************
    // Read channel
    // ****************************************************************

    always_comb begin
        rd_hit = 1'b1;
        rd_word = '0;
        unique case (s_axi_araddr)
            PIN_DATA_ADDR: rd_word[WIDTH-1:0] = pins_sync; // R17
            LATCH_ADDR: rd_word[WIDTH-1:0] = latch_r; // R04
            DIRECTION_ADDR: rd_word[WIDTH-1:0] = dir_r; // R08
            CONTROL_ADDR: rd_word[CTL_WIDTH-1:0] = ctl_r;
            default: rd_hit = 1'b0;
        endcase
        rvalid_nxt = rvalid_r;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_nxt = 1'b1;
            rdata_nxt = rd_word;
            rresp_nxt = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            latch_r <= LATCH_RESET;
            dir_r <= DIRECTION_RESET; // R07
            ctl_r <= CONTROL_RESET[CTL_WIDTH-1:0]; // R05
        end else begin
            aw_held_r <= aw_held_nxt;
            w_held_r <= w_held_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            latch_r <= latch_nxt;
            dir_r <= dir_nxt;
            ctl_r <= ctl_nxt;
        end
    end

    // Read channel registers are kept apart from the write side.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rvalid_r <= 1'b0;
            rresp_r <= RESP_OKAY;
            rdata_r <= '0;
        end else begin
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;

    // ****************************************************************
    // Pin multiplexing
    // ****************************************************************
    logic cap2_here;
    logic pwm_tristate;

    assign cap2_here = ctl_r[CTL_CAPTURE_PIN_SELECT]; // R05 R16
    assign pwm_tristate = pwm_a_en && pwm_shutdown
        && ctl_r[CTL_SHUTDOWN_TRISTATE]; // R13

    always_comb begin
        eff_dir = dir_r; // R02 R03
        eff_out = latch_r;
        digital_off = '0;
        // Pin 2: enhanced PWM channel A wins over plain compare output.
        if (pwm_a_en) begin
            eff_dir[PIN_CAPTURE1] = pwm_tristate; // R06 R13
            eff_out[PIN_CAPTURE1] = pwm_a_out;
        end else if (capture1_en && !dir_r[PIN_CAPTURE1]) begin
            eff_out[PIN_CAPTURE1] = capture1_out; // R12 R18
        end
        if (cap2_here && capture2_en && !dir_r[PIN_CAPTURE2]) begin
            eff_out[PIN_CAPTURE2] = capture2_out; // R11 R18
        end
        if (spi_en && !dir_r[PIN_SERIAL_CLOCK]) begin
            eff_out[PIN_SERIAL_CLOCK] = spi_clock_out; // R14
        end else if (two_wire_en) begin
            // Open-drain style: driven with two_wire_clock_out only while two_wire_clock_drive is set.
            eff_dir[PIN_SERIAL_CLOCK] = !two_wire_clock_drive; // R15 R06
            eff_out[PIN_SERIAL_CLOCK] = two_wire_clock_out;
        end
        if (low_freq_osc_en) begin
            digital_off[PIN_OSC_OUT] = 1'b1; // R09 R18
            digital_off[PIN_OSC_IN] = 1'b1;
            eff_dir[PIN_OSC_OUT] = 1'b1;
            eff_dir[PIN_OSC_IN] = 1'b1;
        end
    end

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_pad // R01
            assign pin_oe[g] = !eff_dir[g] && !digital_off[g];
            assign pin_o[g] = pin_oe[g] ? eff_out[g] : 1'b0;
        end
    endgenerate

    assign osc_analog_en = {2{low_freq_osc_en}}; // R09
    assign capture2_alt_sel = !cap2_here; // R16
    // Peripheral inputs except the two-wire clock read zero while their direction bit is zero.
    assign capture2_in = cap2_here && dir_r[PIN_CAPTURE2]
        && !low_freq_osc_en && pins_sync[PIN_CAPTURE2]; // R11
    assign capture1_in = dir_r[PIN_CAPTURE1]
        && pins_sync[PIN_CAPTURE1]; // R12
    assign spi_clock_in = dir_r[PIN_SERIAL_CLOCK]
        && pins_sync[PIN_SERIAL_CLOCK]; // R14
    assign two_wire_clock_in = pins_sync[PIN_SERIAL_CLOCK]; // R15
    assign two_wire_smbus_levels = ctl_r[CTL_TWO_WIRE_SMBUS]; // R15
    assign secondary_timer_count_in = dir_r[PIN_OSC_OUT]
        && !low_freq_osc_en && pins_sync[PIN_OSC_OUT]; // R10

endmodule // port_c_gpio
`default_nettype wire

// ==== port_c_gpio_sva.sv ====
/*
 * Checker for the third port: bus answers and pin ownership.
 * Assumes it is bound into port_c_gpio and sees only its ports.
 */
`timescale 1ns/1ns
`default_nettype none
module port_c_gpio_sva #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [WIDTH-1:0] pin_o,
    input wire logic [WIDTH-1:0] pin_oe,
    input wire logic [1:0] osc_analog_en,
    input wire logic low_freq_osc_en,
    input wire logic pwm_a_en,
    input wire logic pwm_a_out,
    input wire logic pwm_shutdown,
    input wire logic two_wire_en,
    input wire logic two_wire_clock_drive,
    input wire logic capture2_alt_sel,
    input wire logic secondary_timer_count_in
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    a_reset_inputs: assert property (
        $rose(rstn) && !pwm_a_en && !two_wire_en |-> pin_oe == '0)
        else $error("pins driven after reset");
    a_alt_default: assert property (
        $rose(rstn) |-> !capture2_alt_sel)
        else $error("capture unit not on pin 1 after reset");
    a_oe_after_write: assert property (
        $changed(pin_oe[WIDTH-1:4]) |-> ##[0:1] s_axi_bvalid)
        else $error("upper pin direction moved without a write");
    a_undriven_low: assert property (
        (pin_o & ~pin_oe) == '0)
        else $error("value shown on an undriven pin");
    a_osc_owns: assert property (
        low_freq_osc_en |-> osc_analog_en == 2'h3 && pin_oe[1:0] == 2'h0)
        else $error("oscillator pins still digital");
    a_timer_gate: assert property (
        low_freq_osc_en |-> !secondary_timer_count_in)
        else $error("count input live under oscillator");
    a_pwm_wins: assert property (
        pwm_a_en && !pwm_shutdown |-> pin_oe[2] && pin_o[2] == pwm_a_out)
        else $error("pwm channel not on pin 2");
    a_two_wire_clk: assert property (
        two_wire_en |-> pin_oe[3] == two_wire_clock_drive)
        else $error("two-wire clock drive wrong");
    a_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[2:3] s_axi_bvalid)
        else $error("write response late");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
        else $error("read response late");
endmodule // port_c_gpio_sva
bind port_c_gpio port_c_gpio_sva #(.WIDTH(WIDTH)) u_sva (.clk(clk),
    .rstn(rstn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .pin_o(pin_o), .pin_oe(pin_oe),
    .osc_analog_en(osc_analog_en), .low_freq_osc_en(low_freq_osc_en),
    .pwm_a_en(pwm_a_en), .pwm_a_out(pwm_a_out),
    .pwm_shutdown(pwm_shutdown), .two_wire_en(two_wire_en),
    .two_wire_clock_drive(two_wire_clock_drive),
    .capture2_alt_sel(capture2_alt_sel),
    .secondary_timer_count_in(secondary_timer_count_in));
`default_nettype wire

// ==== port_c_pads.sv ====
/*
 * Outside circuitry on the eight port pins.
 * Assumes pin_o/pin_oe from the port and a level set by the bench.
 */
`timescale 1ns/1ns
`default_nettype none
module port_c_pads (
    input wire logic [7:0] pin_o,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] ext_level,
    output logic [7:0] pin_i
);
    // A wire shows the port's level while driven, else the outside one.
    always_comb begin
        for (int k = 0; k < 8; k++) begin
            pin_i[k] = pin_oe[k] ? pin_o[k] : ext_level[k];
        end
    end
endmodule // port_c_pads
`default_nettype wire

// ==== port_c_pkg.sv ====
/*
 * Constants for the third general-purpose port: register map, field
 * positions, reset values and the list of behaviours the block keeps.
 * Assumes a 32-bit AXI4-Lite register bus and one 100 MHz clock.
 */
// Function
// R01: Eight pins, each individually usable as input or output.
// R02: Direction bit one puts the pin driver in high impedance.
// R03: Direction bit zero drives the pin from its output latch bit.
// R04: Latch register is addressable; reading it returns latch, not pins.
// R05: Pin-select bit one places second capture unit on pin 1; default one.
// R06: Enabled peripherals may force pin direction regardless of direction bit.
// R07: After reset all pins are digital inputs.
// R08: Direction register reads back stored contents despite overrides.
// R09: Oscillator enabled: pins 0 and 1 analog, digital I/O off; the data register still reads both pins' levels.
// R10: Pin 0 as input also feeds the secondary timer count input.
// R11: Second capture unit drives pin 1 or captures from it per direction.
// R12: First capture unit drives pin 2 or captures from it per direction.
// R13: Pin 2 carries enhanced PWM channel A; tristates on shutdown if enabled.
// R14: SPI mode drives or receives serial clock on pin 3 per direction.
// R15: Two-wire mode uses pin 3 as clock; input buffer per module setting.
// R16: Pin-select bit zero routes second capture unit to the neighbouring port.
// R17: Data register reads pin levels; writes update the output latch.
// R18: Priority on a pin: oscillator, then peripheral output, then latch.
package port_c_pkg;

    localparam int PORT_WIDTH = 8;
    localparam int ADDR_WIDTH = 5;

    // ****************************************************************
    // Register byte addresses
    // ****************************************************************
    localparam logic [ADDR_WIDTH-1:0] PIN_DATA_ADDR = 5'h00;
    localparam logic [ADDR_WIDTH-1:0] LATCH_ADDR = 5'h04;
    localparam logic [ADDR_WIDTH-1:0] DIRECTION_ADDR = 5'h08;
    localparam logic [ADDR_WIDTH-1:0] CONTROL_ADDR = 5'h0C;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0] DIRECTION_RESET = 8'hFF;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [7:0] CONTROL_RESET = 8'h01;

    // ****************************************************************
    // Control register fields
    // ****************************************************************
    localparam int CTL_WIDTH = 3;
    localparam int CTL_CAPTURE_PIN_SELECT = 0;
    localparam int CTL_SHUTDOWN_TRISTATE = 1;
    localparam int CTL_TWO_WIRE_SMBUS = 2;

    // ****************************************************************
    // Pin positions
    // ****************************************************************
    localparam int PIN_OSC_OUT = 0;
    localparam int PIN_OSC_IN = 1;
    localparam int PIN_CAPTURE2 = 1;
    localparam int PIN_CAPTURE1 = 2;
    localparam int PIN_SERIAL_CLOCK = 3;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ==== test_port_c_gpio.sv ====
/*
 * Self-checking bench for the third port over AXI4-Lite.
 * Assumes the pad model and checker compile alongside.
 */
`timescale 1ns/1ns
`default_nettype none
module test_port_c_gpio;
import port_c_pkg::*;
logic clk, rstn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
logic [4:0] s_axi_awaddr, s_axi_araddr;
logic [31:0] s_axi_wdata, s_axi_rdata;
logic [3:0] s_axi_wstrb;
logic [1:0] s_axi_bresp, s_axi_rresp, osc_analog_en;
logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
logic s_axi_arready, s_axi_rvalid, s_axi_rready;
logic [7:0] pin_i, pin_o, pin_oe, ext_level;
logic low_freq_osc_en, capture2_en, capture2_out, capture2_in;
logic capture2_alt_sel, capture1_en, capture1_out, capture1_in;
logic pwm_a_en, pwm_a_out, pwm_shutdown, spi_en, spi_clock_out;
logic spi_clock_in, two_wire_en, two_wire_clock_out;
logic two_wire_clock_drive, two_wire_clock_in, two_wire_smbus_levels;
logic secondary_timer_count_in;
int err_total, num_checks;
port_c_gpio dut (.clk(clk), .rstn(rstn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe(pin_oe), .osc_analog_en(osc_analog_en),
    .low_freq_osc_en(low_freq_osc_en), .capture2_en(capture2_en),
    .capture2_out(capture2_out), .capture2_in(capture2_in),
    .capture2_alt_sel(capture2_alt_sel), .capture1_en(capture1_en),
    .capture1_out(capture1_out), .capture1_in(capture1_in),
    .pwm_a_en(pwm_a_en), .pwm_a_out(pwm_a_out),
    .pwm_shutdown(pwm_shutdown), .spi_en(spi_en),
    .spi_clock_out(spi_clock_out), .spi_clock_in(spi_clock_in),
    .two_wire_en(two_wire_en), .two_wire_clock_out(two_wire_clock_out),
    .two_wire_clock_drive(two_wire_clock_drive),
    .two_wire_clock_in(two_wire_clock_in),
    .two_wire_smbus_levels(two_wire_smbus_levels),
    .secondary_timer_count_in(secondary_timer_count_in));
port_c_pads pads (.pin_o(pin_o), .pin_oe(pin_oe),
    .ext_level(ext_level), .pin_i(pin_i));
initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
end
task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
        $display("ALL TESTS PASSED");
    else
        $display("TESTS FAILED");
    $finish;
endtask
task automatic give_up;
    err_total++;
    print_verdict();
endtask
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
        err_total++;
        $display("unexpected %0t got %h want %h", $time, got, exp);
    end
endtask
task automatic wr(input logic [4:0] a, input logic [7:0] d,
                  input logic [1:0] er);
    int n = 0;
    logic aw = 0, w = 0, b = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!b) begin
        @(negedge clk);
        aw |= s_axi_awvalid & s_axi_awready;
        w |= s_axi_wvalid & s_axi_wready;
        b = s_axi_bvalid;
        if (b) chk(32'(s_axi_bresp), 32'(er));
        n++;
        if (n > 50) give_up();
        @(posedge clk);
        if (aw) s_axi_awvalid <= 1'b0;
        if (w) s_axi_wvalid <= 1'b0;
        if (b) s_axi_bready <= 1'b0;
    end
    @(posedge clk);
endtask
task automatic rd(input logic [4:0] a, input logic [31:0] ed,
                  input logic [1:0] er);
    int n = 0;
    logic ar = 0, got = 0;
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    while (!got) begin
        @(negedge clk);
        ar |= s_axi_arvalid & s_axi_arready;
        got = s_axi_rvalid;
        if (got) chk(32'(s_axi_rresp), 32'(er));
        if (got && er === RESP_OKAY) chk(s_axi_rdata, ed);
        n++;
        if (n > 50) give_up();
        @(posedge clk);
        if (ar) s_axi_arvalid <= 1'b0;
        if (got) s_axi_rready <= 1'b0;
    end
    @(posedge clk);
endtask
task automatic pins(input logic [7:0] oe, input logic [7:0] o);
    @(negedge clk);
    chk(32'(pin_oe), 32'(oe));
    chk(32'(pin_o), 32'(o));
    @(posedge clk);
endtask
task automatic t_reset;
    rd(DIRECTION_ADDR, 32'hFF, RESP_OKAY);
    rd(LATCH_ADDR, 32'h00, RESP_OKAY);
    rd(CONTROL_ADDR, 32'h01, RESP_OKAY);
    pins(8'h00, 8'h00);
    chk(32'(capture2_alt_sel), 32'h0);
endtask
task automatic t_regs;
    wr(LATCH_ADDR, 8'hA5, RESP_OKAY);
    wr(DIRECTION_ADDR, 8'h0F, RESP_OKAY);
    pins(8'hF0, 8'hA0);
    wr(PIN_DATA_ADDR, 8'h3C, RESP_OKAY);
    rd(LATCH_ADDR, 32'h3C, RESP_OKAY);
    s_axi_wstrb <= 4'h0;
    wr(LATCH_ADDR, 8'hFF, RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(LATCH_ADDR, 32'h3C, RESP_OKAY);
    rd(PIN_DATA_ADDR, 32'h3A, RESP_OKAY);
    wr(5'h10, 8'hFF, RESP_SLVERR);
    rd(5'h10, 32'h0, RESP_SLVERR);
    rd(DIRECTION_ADDR, 32'h0F, RESP_OKAY);
endtask
task automatic t_periph;
    wr(DIRECTION_ADDR, 8'h00, RESP_OKAY);
    wr(LATCH_ADDR, 8'h00, RESP_OKAY);
    {capture1_en, capture1_out, capture2_en, capture2_out} <= 4'hF;
    {spi_en, spi_clock_out} <= 2'h3;
    pins(8'hFF, 8'h0E);
    {low_freq_osc_en, pwm_a_en, pwm_a_out} <= 3'h6;
    pins(8'hFC, 8'h08);
    wr(CONTROL_ADDR, 8'h03, RESP_OKAY);
    pwm_shutdown <= 1'b1;
    pins(8'hF8, 8'h08);
    wr(DIRECTION_ADDR, 8'hFF, RESP_OKAY);
    {pwm_shutdown, pwm_a_out, low_freq_osc_en} <= 3'h2;
    pins(8'h04, 8'h04);
    rd(DIRECTION_ADDR, 32'hFF, RESP_OKAY);
    {pwm_a_en, capture1_out, capture2_out, spi_clock_out} <= 4'h0;
endtask
task automatic t_inputs;
    ext_level <= 8'h0F;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(32'({capture2_in, capture1_in, spi_clock_in,
        secondary_timer_count_in}), 32'hF);
    @(posedge clk);
    wr(CONTROL_ADDR, 8'h04, RESP_OKAY);
    @(negedge clk);
    chk(32'({capture2_alt_sel, two_wire_smbus_levels, capture2_in}),
        32'h6);
    @(posedge clk);
    {spi_en, two_wire_en, two_wire_clock_drive} <= 3'h3;
    pins(8'h08, 8'h00);
    two_wire_clock_drive <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(32'(two_wire_clock_in), 32'h1);
    pins(8'h00, 8'h00);
endtask
initial begin
    err_total = 0;
    num_checks = 0;
    {rstn, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {low_freq_osc_en, capture2_en, capture2_out, capture1_en} = '0;
    {capture1_out, pwm_a_en, pwm_a_out, pwm_shutdown, spi_en} = '0;
    {spi_clock_out, two_wire_en, two_wire_clock_out} = '0;
    two_wire_clock_drive = 1'b0;
    s_axi_wstrb = 4'hF;
    ext_level = 8'h5A;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_regs();
    t_periph();
    t_inputs();
    print_verdict();
end
endmodule // test_port_c_gpio
`default_nettype wire
